// ### hw/switch_global_control_regs.sv
// Switch-wide frame policy control registers and the decisions they steer.
// Assumes the management port and frame descriptors are on REF_CLK; the strap pin is asynchronous.
//
// Operation
// - Errored frames are forwarded only with pass-all set and sniffer mode active.
// - Transmit pause cleared blocks all PAUSE generation; resets to one.
// - Receive pause cleared ignores received PAUSE frames; resets to one.
// - Length check drops frames whose Length/Type below 1500 mismatches actual length.
// - Aging enable gates address aging; resets to inverse of sampled strap.
// - Aggressive back-off selects non-standard half-duplex back-off; resets to zero.
// - VLAN discard set blocks all crossings; cleared lets known unicast cross.
`timescale 1ns/1ns
`default_nettype none
module switch_global_control_regs #(
   parameter logic [switch_policy_pkg::AGE_CNT_W-1:0] NORMAL_AGE_CYCLES =
      switch_policy_pkg::AGE_CNT_W'(switch_policy_pkg::AGE_NORMAL_CYCLES),
   parameter logic [switch_policy_pkg::AGE_CNT_W-1:0] FAST_AGE_CYCLES   =
      switch_policy_pkg::AGE_CNT_W'(switch_policy_pkg::AGE_FAST_CYCLES)
) (
   input  wire logic                           REF_CLK,
   input  wire logic                           SYS_RST,
   input  wire logic                           AGING_DEFAULT_STRAP_PIN,
   input  wire logic [7:0]                     REG_ADDR,
   input  wire logic                           REG_WR,
   input  wire logic [7:0]                     REG_WDATA,
   input  wire logic                           REG_RD,
   output logic      [7:0]                     REG_RDATA,
   input  wire logic                           SNIFFER_MODE_ACTIVE,
   input  wire switch_policy_pkg::frame_desc_t FRAME_IN,
   output switch_policy_pkg::verdict_t         VERDICT,
   input  wire logic                           PAUSE_TX_REQ,
   output logic                                PAUSE_TX_GO,
   input  wire logic                           PAUSE_RX_SEEN,
   output logic                                PAUSE_RX_APPLY,
   output logic                                AGING_ENABLE,
   output logic                                AGE_TICK,
   output logic                                AGGR_BACKOFF_EN
);
   import switch_policy_pkg::*;

   logic       strap_s1_q;
   logic       strap_s2_q;
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_a_d;
   logic [7:0] ctrl_b_q;
   logic [7:0] ctrl_b_d;
   logic [7:0] rdata_d;
   verdict_t   verdict_d;
   logic       pause_tx_d;
   logic       pause_rx_d;
   logic       drop_err;
   logic       drop_len;
   logic       drop_vlan;

   // Strap synchroniser runs through reset so the level is settled at release.
   always_ff @(posedge REF_CLK) begin
      strap_s1_q <= AGING_DEFAULT_STRAP_PIN;
      strap_s2_q <= strap_s1_q;
   end

   // Register writes; other addresses leave the fields unchanged.
   always_comb begin
      ctrl_a_d = ctrl_a_q;
      ctrl_b_d = ctrl_b_q;
      rdata_d  = REG_RDATA;
      if (REG_WR && (REG_ADDR == ADDR_CTRL_A)) begin
         ctrl_a_d = REG_WDATA;
      end
      if (REG_WR && (REG_ADDR == ADDR_CTRL_B)) begin
         ctrl_b_d = REG_WDATA & CTRL_B_WRITE_MASK;
      end
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_CTRL_A: rdata_d = ctrl_a_q;
            ADDR_CTRL_B: rdata_d = ctrl_b_q;
            default:     rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl_a_q              <= CTRL_A_RESET;
         ctrl_a_q[A_AGING_BIT] <= ~strap_s2_q;
         ctrl_b_q              <= CTRL_B_RESET;
         REG_RDATA             <= READ_UNMAPPED;
      end else begin
         ctrl_a_q  <= ctrl_a_d;
         ctrl_b_q  <= ctrl_b_d;
         REG_RDATA <= rdata_d;
      end
   end

   // Per-frame verdict, one cycle after the descriptor.
   always_comb begin
      drop_err  = FRAME_IN.has_error && !(ctrl_a_q[A_PASS_ALL_BIT] && SNIFFER_MODE_ACTIVE);
      drop_len  = ctrl_a_q[A_LEN_CHECK_BIT] && (FRAME_IN.len_type < LEN_TYPE_LIMIT)
                  && (FRAME_IN.len_type != FRAME_IN.actual_len);
      drop_vlan = FRAME_IN.cross_vlan
                  && (ctrl_b_q[B_VLAN_DISCARD_BIT] || !FRAME_IN.known_unicast);
      verdict_d.valid   = FRAME_IN.valid;
      verdict_d.forward = FRAME_IN.valid && !drop_err && !drop_len && !drop_vlan;
      pause_tx_d = PAUSE_TX_REQ && ctrl_a_q[A_PAUSE_TX_BIT];
      pause_rx_d = PAUSE_RX_SEEN && ctrl_a_q[A_PAUSE_RX_BIT];
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         VERDICT         <= '0;
         PAUSE_TX_GO     <= 1'b0;
         PAUSE_RX_APPLY  <= 1'b0;
         AGING_ENABLE    <= 1'b0;
         AGGR_BACKOFF_EN <= 1'b0;
      end else begin
         VERDICT         <= verdict_d;
         PAUSE_TX_GO     <= pause_tx_d;
         PAUSE_RX_APPLY  <= pause_rx_d;
         AGING_ENABLE    <= ctrl_a_q[A_AGING_BIT];
         AGGR_BACKOFF_EN <= ctrl_a_q[A_AGGR_BACKOFF_BIT];
      end
   end

   age_tick_gen #(
      .NORMAL_CYCLES (NORMAL_AGE_CYCLES),
      .FAST_CYCLES   (FAST_AGE_CYCLES)
   ) u_age (
      .clk    (REF_CLK),
      .rst    (SYS_RST),
      .enable (ctrl_a_q[A_AGING_BIT]),
      .fast   (ctrl_a_q[A_FAST_AGE_BIT]),
      .tick_q (AGE_TICK)
   );

   pass_all_gate_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      VERDICT.forward && $past(FRAME_IN.has_error)
      |-> $past(ctrl_a_q[A_PASS_ALL_BIT]) && $past(SNIFFER_MODE_ACTIVE))
      else $error("Errored frame forwarded without pass-all in sniffer mode.");

   pause_tx_gate_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !$past(SYS_RST) |-> PAUSE_TX_GO == ($past(PAUSE_TX_REQ) && $past(ctrl_a_q[A_PAUSE_TX_BIT])))
      else $error("Pause generation does not follow its enable.");

   pause_rx_gate_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !$past(SYS_RST) |-> PAUSE_RX_APPLY == ($past(PAUSE_RX_SEEN) && $past(ctrl_a_q[A_PAUSE_RX_BIT])))
      else $error("Received pause handling does not follow its enable.");

   length_drop_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      FRAME_IN.valid && ctrl_a_q[A_LEN_CHECK_BIT] && (FRAME_IN.len_type < LEN_TYPE_LIMIT)
      && (FRAME_IN.len_type != FRAME_IN.actual_len) |=> VERDICT.valid && !VERDICT.forward)
      else $error("Length mismatch frame was not dropped.");

   strap_default_a: assert property (@(posedge REF_CLK)
      !SYS_RST && $past(SYS_RST) |-> ctrl_a_q[A_AGING_BIT] == !$past(strap_s2_q))
      else $error("Aging default is not the inverted strap level.");

   aging_off_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      AGE_TICK |-> $past(ctrl_a_q[A_AGING_BIT]))
      else $error("Aging tick while aging disabled.");

   backoff_follow_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      REG_WR && (REG_ADDR == ADDR_CTRL_A)
      |-> ##2 AGGR_BACKOFF_EN == $past(REG_WDATA[A_AGGR_BACKOFF_BIT], 2))
      else $error("Back-off enable did not follow the write.");

   vlan_cross_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      VERDICT.forward && $past(FRAME_IN.cross_vlan)
      |-> !$past(ctrl_b_q[B_VLAN_DISCARD_BIT]) && $past(FRAME_IN.known_unicast))
      else $error("Frame crossed a port-VLAN boundary illegally.");

   field_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !REG_WR |=> $stable(ctrl_a_q) && $stable(ctrl_b_q))
      else $error("Control field changed without a write.");

   read_back_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      REG_WR && (REG_ADDR == ADDR_CTRL_A) ##1 REG_RD && (REG_ADDR == ADDR_CTRL_A) && !REG_WR
      |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("Read back differs from last write.");

endmodule
`default_nettype wire

// ### common/switch_policy_pkg.sv
// Shared constants and types for the switch-wide frame policy register bank.
// Assumes a single 25 MHz core clock and byte-wide management registers.
package switch_policy_pkg;

   localparam logic [7:0]  ADDR_CTRL_A        = 8'h03;
   localparam logic [7:0]  ADDR_CTRL_B        = 8'h04;
   localparam logic [7:0]  READ_UNMAPPED      = 8'h00;

   localparam int          A_PASS_ALL_BIT     = 7;
   localparam int          A_RSVD_BIT         = 6;
   localparam int          A_PAUSE_TX_BIT     = 5;
   localparam int          A_PAUSE_RX_BIT     = 4;
   localparam int          A_LEN_CHECK_BIT    = 3;
   localparam int          A_AGING_BIT        = 2;
   localparam int          A_FAST_AGE_BIT     = 1;
   localparam int          A_AGGR_BACKOFF_BIT = 0;
   localparam int          B_VLAN_DISCARD_BIT = 7;

   localparam logic [7:0]  CTRL_A_RESET       = 8'h30;
   localparam logic [7:0]  CTRL_B_RESET       = 8'h80;
   localparam logic [7:0]  CTRL_B_WRITE_MASK  = 8'h80;

   localparam logic [15:0] LEN_TYPE_LIMIT     = 16'h05dc;

   localparam longint      CLK_HZ             = 25000000;
   localparam longint      AGE_NORMAL_S       = 200;
   localparam longint      AGE_FAST_US        = 800;
   localparam longint      US_PER_S           = 1000000;
   localparam longint      AGE_NORMAL_CYCLES  = AGE_NORMAL_S * CLK_HZ;
   localparam longint      AGE_FAST_CYCLES    = (AGE_FAST_US * CLK_HZ) / US_PER_S;
   localparam int          AGE_CNT_W          = 33;

   typedef struct packed {
      logic        valid;
      logic        has_error;
      logic [15:0] len_type;
      logic [15:0] actual_len;
      logic        known_unicast;
      logic        cross_vlan;
   } frame_desc_t;

   typedef struct packed {
      logic valid;
      logic forward;
   } verdict_t;

endpackage

// ### hw/age_tick_gen.sv
// Address-table aging tick generator with a normal and a fast period.
// Assumes enable and fast come from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module age_tick_gen #(
   parameter logic [switch_policy_pkg::AGE_CNT_W-1:0] NORMAL_CYCLES =
      switch_policy_pkg::AGE_CNT_W'(switch_policy_pkg::AGE_NORMAL_CYCLES),
   parameter logic [switch_policy_pkg::AGE_CNT_W-1:0] FAST_CYCLES   =
      switch_policy_pkg::AGE_CNT_W'(switch_policy_pkg::AGE_FAST_CYCLES)
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic fast,
   output logic      tick_q
);
   import switch_policy_pkg::*;

   localparam logic [AGE_CNT_W-1:0] CNT_ONE = AGE_CNT_W'(1);

   logic [AGE_CNT_W-1:0] cnt_q;
   logic [AGE_CNT_W-1:0] cnt_d;
   logic [AGE_CNT_W-1:0] period;
   logic                 tick_d;

   // A fast request shortens the running cycle at once.
   always_comb begin
      period = fast ? FAST_CYCLES : NORMAL_CYCLES;
      cnt_d  = '0;
      tick_d = 1'b0;
      if (enable) begin
         if (cnt_q >= period - CNT_ONE) begin
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

endmodule
`default_nettype wire

// ### sim/tb_switch_global_control_regs.sv
// Testbench for the switch-wide policy registers, with read and verdict scoreboards.
// Assumes shortened aging periods and that the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none
module tb_switch_global_control_regs;
   import switch_policy_pkg::*;
   localparam int NCYC = 64;
   localparam int FCYC = 8;
   logic        clk = 0, rst = 1, strap = 0, wr = 0, rd = 0, snf = 0, txr = 0, rxs = 0;
   logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat, a_m, b_m;
   frame_desc_t fin = '0;
   verdict_t    vd;
   logic        go, apply, age_en, tick, aggr, rd_was, fr_was;
   int          n_errors = 0, comparisons = 0, seed = 87;
   logic [7:0]  rd_q[$];
   logic [3:0]  vd_q[$];
   always #20 clk = ~clk;
   switch_global_control_regs #(.NORMAL_AGE_CYCLES(AGE_CNT_W'(NCYC)), .FAST_AGE_CYCLES(AGE_CNT_W'(FCYC))) dut_u (
      .REF_CLK(clk), .SYS_RST(rst), .AGING_DEFAULT_STRAP_PIN(strap), .REG_ADDR(addr), .REG_WR(wr),
      .REG_WDATA(wdat), .REG_RD(rd), .REG_RDATA(rdat), .SNIFFER_MODE_ACTIVE(snf), .FRAME_IN(fin),
      .VERDICT(vd), .PAUSE_TX_REQ(txr), .PAUSE_TX_GO(go), .PAUSE_RX_SEEN(rxs), .PAUSE_RX_APPLY(apply),
      .AGING_ENABLE(age_en), .AGE_TICK(tick), .AGGR_BACKOFF_EN(aggr));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
      chk(32'(got), 32'(exp));
   endtask
   task automatic chk_verdict(input logic [3:0] got, input logic [3:0] exp);
      chk(32'(got), 32'(exp));
   endtask
   task automatic cyc();
      @(posedge clk);
      #2;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      cyc();
      wr = 1;
      addr = a;
      wdat = d;
      cyc();
      wr = 0;
      if (a == ADDR_CTRL_A) a_m = d;
      if (a == ADDR_CTRL_B) b_m = d & CTRL_B_WRITE_MASK;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      cyc();
      rd = 1;
      addr = a;
      rd_q.push_back(e);
      cyc();
      rd = 0;
   endtask
   // Write followed at once by a read of the same register.
   task automatic reg_wr_rd(input logic [7:0] a, input logic [7:0] d);
      cyc();
      wr = 1;
      addr = a;
      wdat = d;
      cyc();
      wr = 0;
      rd = 1;
      if (a == ADDR_CTRL_A) a_m = d;
      if (a == ADDR_CTRL_B) b_m = d & CTRL_B_WRITE_MASK;
      rd_q.push_back((a == ADDR_CTRL_A) ? a_m : b_m);
      cyc();
      rd = 0;
   endtask
   // Back-to-back descriptors with random error, length, VLAN, sniffer and pause inputs.
   task automatic frame();
      logic [31:0] w;
      logic        drop;
      w = $random(seed);
      cyc();
      fin = '{1'b1, w[0], 16'(1495 + w[3:1]), 16'(1495 + w[3:1] + w[4]), w[5], w[6]};
      snf = w[7];
      txr = w[8];
      rxs = w[9];
      drop = (fin.has_error & ~(a_m[A_PASS_ALL_BIT] & snf))
           | (a_m[A_LEN_CHECK_BIT] & (fin.len_type < LEN_TYPE_LIMIT) & (fin.len_type != fin.actual_len))
           | (fin.cross_vlan & (b_m[B_VLAN_DISCARD_BIT] | ~fin.known_unicast));
      vd_q.push_back({1'b1, ~drop, txr & a_m[A_PAUSE_TX_BIT], rxs & a_m[A_PAUSE_RX_BIT]});
   endtask
   task automatic idle();
      cyc();
      fin = '0;
      txr = 0;
      rxs = 0;
   endtask
   // Measures the spacing of aging ticks; the first wait only aligns to a tick.
   task automatic period(output int n);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            cyc();
            n++;
         end while (tick !== 1'b1 && n < 200);
      end
   endtask
   always @(posedge clk) begin
      rd_was = rd;
      fr_was = fin.valid;
      #1;
      if (rd_was) chk_read(rdat, rd_q.pop_front());
      if (fr_was || vd.valid !== 1'b0) chk_verdict({vd, go, apply}, vd_q.pop_front());
   end
   task automatic final_report();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      final_report();
   end
   initial begin
      int n;
      for (int p = 0; p < 2; p++) begin
         rst = 1;
         strap = p[0];
         repeat (4) cyc();
         rst = 0;
         a_m = CTRL_A_RESET;
         a_m[A_AGING_BIT] = ~strap;
         b_m = CTRL_B_RESET;
         reg_rd(ADDR_CTRL_A, a_m);
         reg_rd(ADDR_CTRL_B, b_m);
         chk(age_en, !strap);
         reg_rd(8'h05, READ_UNMAPPED);
         reg_wr(8'h05, 8'hff);
         reg_rd(ADDR_CTRL_A, a_m);
      end
      for (int g = 0; g < 6; g++) begin
         reg_wr_rd(ADDR_CTRL_A, (8'($random(seed)) & 8'hbf) | ((g == 2) ? 8'h88 : 8'h00));
         reg_wr_rd(ADDR_CTRL_B, g[0] ? 8'h7f : 8'hff);
         chk(aggr, a_m[A_AGGR_BACKOFF_BIT]);
         chk(age_en, a_m[A_AGING_BIT]);
         for (int j = 0; j < 10; j++) frame();
         idle();
      end
      reg_wr(ADDR_CTRL_A, 8'h04);
      period(n);
      chk(n, NCYC);
      reg_wr(ADDR_CTRL_A, 8'h06);
      period(n);
      chk(n, FCYC);
      reg_wr(ADDR_CTRL_A, 8'h00);
      n = 0;
      repeat (150) begin
         cyc();
         n += int'(tick);
      end
      chk(n, 0);
      chk(age_en, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
